// >>> hdl/crc_pkg.sv
package crc_pkg;

   // ************************************************************
   // widths
   // ************************************************************
   localparam int unsigned CRC_W = 16;
   localparam int unsigned SEL_W = 3;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   typedef logic [CRC_W-1:0] crc_word_t;
   typedef logic [SEL_W-1:0] poly_sel_t;

   // ************************************************************
   // polynomial select codes
   // ************************************************************
   localparam poly_sel_t SEL_CRC16 = 3'h0;
   localparam poly_sel_t SEL_CRC16_REV = 3'h1;
   localparam poly_sel_t SEL_POLY16_B = 3'h2;
   localparam poly_sel_t SEL_CRC12 = 3'h3;
   localparam poly_sel_t SEL_POLY8_A = 3'h4;
   localparam poly_sel_t SEL_LRC8 = 3'h5;
   localparam poly_sel_t SEL_CCITT = 3'h6;
   localparam poly_sel_t SEL_CCITT_REV = 3'h7;

   // feedback taps, top power left out
   localparam crc_word_t TAPS_CRC16 = 16'h8005;
   localparam crc_word_t TAPS_CRC16_REV = 16'h4003;
   localparam crc_word_t TAPS_POLY16_B = 16'hA097;
   localparam crc_word_t TAPS_CRC12 = 16'h080F;
   localparam crc_word_t TAPS_POLY8_A = 16'h00B3;
   localparam crc_word_t TAPS_LRC8 = 16'h0001;
   localparam crc_word_t TAPS_CCITT = 16'h1021;
   localparam crc_word_t TAPS_CCITT_REV = 16'h0811;

   // active stage masks per degree
   localparam crc_word_t MASK_DEG16 = 16'hFFFF;
   localparam crc_word_t MASK_DEG12 = 16'h0FFF;
   localparam crc_word_t MASK_DEG8 = 16'h00FF;

   // good-frame residue, bit i holds x^i
   localparam crc_word_t SDLC_RESIDUE = 16'h1D0F;
   localparam crc_word_t CRC_RESET = 16'h0000;

   // ************************************************************
   // register port map
   // ************************************************************
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
   localparam int unsigned CTRL_CLEAR_BIT = 0;
   localparam int unsigned CTRL_PRESET_BIT = 1;
   localparam int unsigned STAT_ERR_BIT = 16;
   localparam int unsigned STAT_SOUT_BIT = 17;
   localparam int unsigned STAT_SEL_LSB = 18;
   localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

endpackage : crc_pkg

// >>> hdl/serial_crc_generator_checker.sv
`timescale 1ns/100ps
// Overview of operation
// - eight polynomials, chosen by three select inputs, drive all accumulation
// - select codes map to the listed CRC-16, CRC-12, 8-bit and CCITT polynomials
// - data sampled and register advanced on each falling shift clock edge
// - incoming bit xor top stage drives the selected feedback taps
// - active stage count equals selected polynomial degree
// - short polynomials right-justified so check bits leave the serial output
// - enable low shifts remainder out with no feedback
// - without pattern match, error low only when remainder is all zero
// - error holds until next falling edge, clear or preset
// - pattern match low in last bit: error low only on SDLC residue
// - master clear high zeroes every register bit at the next clk edge
// - preset low sets active stages, clears the unused ones
//
// limitations: the clear and preset pins act at the next clk edge, not at once;
// the shift clock must stay low and high for at least one clk cycle each;
// a select change mid-message only masks the register, so clear or preset first;
// the control word reads back as zero, its bits are one-shot commands;
// the error flag means something only after the last check bit of a frame
module serial_crc_generator_checker
   import crc_pkg::*;
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic shift_clock_n_in,
   input wire logic serial_data_in,
   input wire logic check_word_enable_in,
   input wire logic poly_select_bit0_in,
   input wire logic poly_select_bit1_in,
   input wire logic poly_select_bit2_in,
   input wire logic master_clear_in,
   input wire logic preset_n_in,
   input wire logic pattern_match_enable_n_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] wr_data_in,
   input wire logic wr_strobe_in,
   input wire logic rd_strobe_in,
   output logic [DATA_W-1:0] rd_data_out,
   output logic serial_out,
   output logic error_flag_out
);

   // ************************************************************
   // helper functions
   // ************************************************************
   // divisor taps, top power implied by the stage count
   function automatic crc_word_t poly_taps(input poly_sel_t sel);
      crc_word_t t;
      t = TAPS_CRC16;
      unique case (sel)
         SEL_CRC16: t = TAPS_CRC16;
         SEL_CRC16_REV: t = TAPS_CRC16_REV;
         SEL_POLY16_B: t = TAPS_POLY16_B;
         SEL_CRC12: t = TAPS_CRC12;
         SEL_POLY8_A: t = TAPS_POLY8_A;
         SEL_LRC8: t = TAPS_LRC8;
         SEL_CCITT: t = TAPS_CCITT;
         SEL_CCITT_REV: t = TAPS_CCITT_REV;
      endcase
      return t;
   endfunction : poly_taps

   // active stages sit in the low bits for short polynomials
   function automatic crc_word_t stage_mask(input poly_sel_t sel);
      crc_word_t m;
      m = MASK_DEG16;
      unique case (sel)
         SEL_CRC16: m = MASK_DEG16;
         SEL_CRC16_REV: m = MASK_DEG16;
         SEL_POLY16_B: m = MASK_DEG16;
         SEL_CRC12: m = MASK_DEG12;
         SEL_POLY8_A: m = MASK_DEG8;
         SEL_LRC8: m = MASK_DEG8;
         SEL_CCITT: m = MASK_DEG16;
         SEL_CCITT_REV: m = MASK_DEG16;
      endcase
      return m;
   endfunction : stage_mask

   // top active stage, whatever the degree
   function automatic logic top_stage(input crc_word_t r, input poly_sel_t sel);
      logic b;
      b = r[15];
      unique case (sel)
         SEL_CRC16: b = r[15];
         SEL_CRC16_REV: b = r[15];
         SEL_POLY16_B: b = r[15];
         SEL_CRC12: b = r[11];
         SEL_POLY8_A: b = r[7];
         SEL_LRC8: b = r[7];
         SEL_CCITT: b = r[15];
         SEL_CCITT_REV: b = r[15];
      endcase
      return b;
   endfunction : top_stage

   // ************************************************************
   // state
   // ************************************************************
   // remainder, bit i holds x^i
   crc_word_t crc_reg;
   crc_word_t crc_next;

   // shift clock level seen at the previous edge
   logic shift_clk_q_reg;

   // output copies, kept in flops so no pin glitches on a select change
   logic sout_reg;
   logic sout_next;
   logic err_reg;
   logic err_next;

   // read port
   logic [DATA_W-1:0] rd_data_reg;
   logic [DATA_W-1:0] rd_data_next;

   // ************************************************************
   // control decode
   // ************************************************************
   poly_sel_t sel;
   crc_word_t taps;
   crc_word_t mask;
   logic shift_fall;
   logic ctrl_wr;
   logic soft_clear;
   logic soft_preset;
   logic pin_clear;
   logic pin_preset;
   logic do_clear;
   logic do_preset;

   // select is decoded every cycle; there is no latch behind it
   assign sel = {poly_select_bit2_in, poly_select_bit1_in,
                 poly_select_bit0_in};
   assign taps = poly_taps(sel);
   assign mask = stage_mask(sel);

   // pins are synchronous, so one stage is enough to see the edge
   // a shift clock held low for many cycles still counts once
   assign shift_fall = shift_clk_q_reg & ~shift_clock_n_in;

   // software commands share the pin priority: clear, then preset
   assign ctrl_wr = wr_strobe_in & (addr_in == ADDR_CTRL);
   assign soft_clear = ctrl_wr & wr_data_in[CTRL_CLEAR_BIT];
   assign soft_preset = ctrl_wr & wr_data_in[CTRL_PRESET_BIT];

   // the asynchronous pin controls act on the next clock edge here
   assign pin_clear = master_clear_in;
   assign pin_preset = ~preset_n_in;
   // clear is tested first so a stuck preset pin cannot hide it
   assign do_clear = pin_clear | soft_clear;
   assign do_preset = (pin_preset | soft_preset) & ~do_clear;

   // ************************************************************
   // update events
   // ************************************************************
   // each of these rewrites the remainder, so the error flag is
   // recomputed on every one; between them the error flag holds and the serial output moves only on a select change
   logic ev_any;

   assign ev_any = do_clear | do_preset | shift_fall;

   // ************************************************************
   // divider datapath
   // ************************************************************
   logic top_bit;
   logic feedback;
   crc_word_t shifted;
   crc_word_t tap_term;
   crc_word_t accum;

   assign top_bit = top_stage(crc_reg, sel);
   // outside logic keeps the enable high through message and
   // received check bits; low means unload the remainder
   assign feedback = check_word_enable_in
                     & (serial_data_in ^ top_bit);
   // shifting into bit 0 keeps short polynomials right-justified
   assign shifted = {crc_reg[CRC_W-2:0], 1'b0};
   // with the enable low this is a plain shift, no taps
   assign tap_term = feedback ? taps : CRC_RESET;
   // stages above the degree are masked so they stay zero
   assign accum = (shifted ^ tap_term) & mask;

   always_comb begin
      crc_next = crc_reg;
      if (do_clear) begin
         crc_next = CRC_RESET;
      end else if (do_preset) begin
         crc_next = mask;
      end else if (shift_fall) begin
         crc_next = accum;
      end
   end

   // ************************************************************
   // serial output and error flag
   // ************************************************************
   crc_word_t residue_target;
   logic residue_ok;

   // pattern match pin is sampled during the last bit's edge
   assign residue_target = pattern_match_enable_n_in ? CRC_RESET
                           : SDLC_RESIDUE;
   // compared against the value being loaded, so the flag moves
   // in the same edge as the remainder
   assign residue_ok = (crc_next == residue_target);

   // the output copy follows the register so that it stays in step
   assign sout_next = top_stage(crc_next, sel);

   always_comb begin
      err_next = err_reg;
      // the flag only moves when the remainder is rewritten
      if (ev_any) begin
         err_next = ~residue_ok;
      end
   end

   // ************************************************************
   // register port
   // ************************************************************
   logic [DATA_W-1:0] status_word;
   logic stat_rd;

   // layout, top down: padding, select, serial copy, error, remainder
   assign status_word = {{(DATA_W - STAT_SEL_LSB - SEL_W){1'b0}},
                         sel, sout_reg, err_reg, crc_reg};
   assign stat_rd = rd_strobe_in & (addr_in == ADDR_STATUS);

   // data stand for one cycle only; control reads back as zero,
   // its bits are self-clearing commands
   assign rd_data_next = stat_rd ? status_word : RD_ZERO;

   // ************************************************************
   // flip-flops
   // ************************************************************
   // remainder
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         crc_reg <= CRC_RESET;
      end else begin
         crc_reg <= crc_next;
      end
   end

   // history resets high so a shift clock already low at release
   // counts as one fall on the first edge
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         shift_clk_q_reg <= 1'b1;
      end else begin
         shift_clk_q_reg <= shift_clock_n_in;
      end
   end

   // serial copy follows the remainder and the select
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sout_reg <= 1'b0;
      end else begin
         sout_reg <= sout_next;
      end
   end

   // error flag holds between rewrites
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         err_reg <= 1'b0;
      end else begin
         err_reg <= err_next;
      end
   end

   // read data, one cycle wide; zero keeps the bus quiet otherwise
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_data_reg <= RD_ZERO;
      end else begin
         rd_data_reg <= rd_data_next;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // SDLC inversion and gating into the line stay outside;
   // this block only watches the stream
   // every pin comes straight from a flop
   assign serial_out = sout_reg;
   assign error_flag_out = err_reg;
   assign rd_data_out = rd_data_reg;

endmodule : serial_crc_generator_checker

// >>> verif/crc_checker_asserts.sv
`timescale 1ns/100ps
module crc_checker
   import crc_pkg::*;
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic shift_clock_n_in,
   input wire logic check_word_enable_in,
   input wire logic poly_select_bit0_in,
   input wire logic poly_select_bit1_in,
   input wire logic poly_select_bit2_in,
   input wire logic master_clear_in,
   input wire logic preset_n_in,
   input wire logic pattern_match_enable_n_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic wr_strobe_in,
   input wire logic rd_strobe_in,
   input wire logic [DATA_W-1:0] rd_data_out,
   input wire logic serial_out,
   input wire logic error_flag_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   wire [2:0] sel_w = {poly_select_bit2_in, poly_select_bit1_in, poly_select_bit0_in};
   wire quiet = !master_clear_in && preset_n_in && !wr_strobe_in;
   // a high shift clock cannot be a fall, so nothing may move
   sequence s_idle;
      quiet && shift_clock_n_in && $stable(sel_w);
   endsequence
   sequence s_drain;
      master_clear_in ##1 (quiet && !check_word_enable_in) [*4];
   endsequence
   AST_CLR_ZERO: assert property (master_clear_in |=> !serial_out)
      else $error("clear left output high");
   AST_CLR_WINS: assert property (master_clear_in && !preset_n_in |=> !serial_out)
      else $error("preset beat clear");
   AST_CLR_ERR: assert property (master_clear_in |=>
      error_flag_out != $past(pattern_match_enable_n_in)) else $error("error after clear");
   AST_PRE_SET: assert property (!preset_n_in && !master_clear_in && !wr_strobe_in |=>
      serial_out && error_flag_out) else $error("preset did not set top stage");
   AST_HOLD: assert property (s_idle |=> $stable(serial_out) && $stable(error_flag_out))
      else $error("outputs moved without a shift");
   AST_DRAIN: assert property (s_drain |=> !serial_out)
      else $error("cleared register gained bits");
   AST_RD_ZERO: assert property (!rd_strobe_in |=> rd_data_out == RD_ZERO)
      else $error("read data not zero");
   AST_UNMAP: assert property (rd_strobe_in && addr_in != ADDR_STATUS |=> rd_data_out == RD_ZERO)
      else $error("unmapped read not zero");
   AST_RD_STAT: assert property (rd_strobe_in && addr_in == ADDR_STATUS ##0 s_idle |=>
      rd_data_out[STAT_ERR_BIT] == error_flag_out && rd_data_out[STAT_SOUT_BIT] == serial_out)
      else $error("status bits disagree with pins");
endmodule : crc_checker
bind serial_crc_generator_checker crc_checker u_chk (.clk_in(clk_in), .arst_n_in(arst_n_in),
   .shift_clock_n_in(shift_clock_n_in), .check_word_enable_in(check_word_enable_in),
   .poly_select_bit0_in(poly_select_bit0_in), .poly_select_bit1_in(poly_select_bit1_in),
   .poly_select_bit2_in(poly_select_bit2_in), .master_clear_in(master_clear_in),
   .preset_n_in(preset_n_in), .pattern_match_enable_n_in(pattern_match_enable_n_in),
   .addr_in(addr_in), .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in),
   .rd_data_out(rd_data_out), .serial_out(serial_out), .error_flag_out(error_flag_out));

// >>> verif/serial_framer.sv
`timescale 1ns/100ps
module serial_framer (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic go_in,
   input wire logic [31:0] bits_in,
   input wire logic [5:0] count_in,
   output logic shift_clock_n_out,
   output logic data_out,
   output logic busy_out
);
   logic [5:0] left_reg;
   // ******
   // framing
   // ******
   // one bit per two clocks; the data line toggles whenever it carries no bit, except in the cycle that ends the frame
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         shift_clock_n_out <= 1'b1;
         data_out <= 1'b0;
         busy_out <= 1'b0;
         left_reg <= '0;
      end else if (!busy_out) begin
         busy_out <= go_in;
         left_reg <= count_in;
         data_out <= ~data_out;
      end else if (!shift_clock_n_out) begin
         shift_clock_n_out <= 1'b1;
         data_out <= ~data_out;
      end else if (left_reg == 6'h00) begin
         busy_out <= 1'b0;
      end else begin
         shift_clock_n_out <= 1'b0;
         data_out <= bits_in[left_reg-6'h01]; // oldest bit first
         left_reg <= left_reg - 6'h01;
      end
   end
endmodule : serial_framer

// >>> verif/serial_crc_generator_checker_tb.sv
`timescale 1ns/100ps
module serial_crc_generator_checker_tb
   import crc_pkg::*;
;
   logic clk_in, arst_n_in, check_word_enable, mclr, pre_n, pme_n, wr, rd, go, sclk_n, sdat, busy, sout, err;
   poly_sel_t sel;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, v;
   logic [31:0] bits;
   logic [5:0] nb;
   int err_count = 0;
   int n_tests = 0;
   localparam crc_word_t TAPS [8] = '{TAPS_CRC16, TAPS_CRC16_REV, TAPS_POLY16_B,
      TAPS_CRC12, TAPS_POLY8_A, TAPS_LRC8, TAPS_CCITT, TAPS_CCITT_REV};
   serial_crc_generator_checker u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
      .shift_clock_n_in(sclk_n), .serial_data_in(sdat), .check_word_enable_in(check_word_enable),
      .poly_select_bit0_in(sel[0]), .poly_select_bit1_in(sel[1]), .poly_select_bit2_in(sel[2]),
      .master_clear_in(mclr), .preset_n_in(pre_n), .pattern_match_enable_n_in(pme_n),
      .addr_in(addr), .wr_data_in(wdata), .wr_strobe_in(wr), .rd_strobe_in(rd),
      .rd_data_out(rdata), .serial_out(sout), .error_flag_out(err));
   serial_framer u_far (.clk_in(clk_in), .arst_n_in(arst_n_in), .go_in(go), .bits_in(bits),
      .count_in(nb), .shift_clock_n_out(sclk_n), .data_out(sdat), .busy_out(busy));
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   function automatic crc_word_t mask_of(poly_sel_t s);
      if (s == SEL_CRC12) return MASK_DEG12;
      if (s inside {SEL_POLY8_A, SEL_LRC8}) return MASK_DEG8;
      return MASK_DEG16;
   endfunction : mask_of
   function automatic crc_word_t crc(crc_word_t r, logic [31:0] b, int k, poly_sel_t s);
      crc_word_t m;
      m = mask_of(s);
      for (int i = k - 1; i >= 0; i--) begin
         r = ((r << 1) ^ ((b[i] ^ |(r & (m ^ (m >> 1)))) ? TAPS[s] : 16'h0000)) & m;
      end
      return r;
   endfunction : crc
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task rd_reg(input logic [ADDR_W-1:0] a);
      @(posedge clk_in) {rd, addr} <= {1'b1, a};
      @(posedge clk_in) rd <= 1'b0;
      @(posedge clk_in) v = rdata;
   endtask : rd_reg
   task wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_in) {wr, addr, wdata} <= {1'b1, a, d};
      @(posedge clk_in) wr <= 1'b0;
   endtask : wr_reg
   task pins(input logic c, input logic p);
      @(posedge clk_in) {mclr, pre_n} <= {c, !p};
      @(posedge clk_in) {mclr, pre_n} <= 2'b01;
   endtask : pins
   task send(input logic [31:0] b, input int k);
      @(posedge clk_in) {bits, nb, go} <= {b, 6'(k), 1'b1};
      @(posedge clk_in) go <= 1'b0;
      @(posedge clk_in);
      for (int i = 0; i < 80 && busy; i++) @(posedge clk_in);
      chk(busy, 1'b0, "frame done");
   endtask : send
   task t_preset;
      poly_sel_t ps [3] = '{SEL_CRC16, SEL_CRC12, SEL_POLY8_A};
      for (int i = 0; i < 3; i++) begin
         sel <= ps[i];
         pins(1'b0, 1'b1);
         rd_reg(ADDR_STATUS);
         chk(v[15:0], mask_of(ps[i]), "preset");
      end
      check_word_enable <= 1'b0;
      pins(1'b1, 1'b1);
      repeat (6) @(posedge clk_in);
      rd_reg(ADDR_STATUS);
      chk(v[15:0], 16'h0000, "both");
      sel <= SEL_CRC16;
      wr_reg(ADDR_CTRL, 32'h0000_0002);
      rd_reg(ADDR_STATUS);
      chk(v[15:0], MASK_DEG16, "soft preset");
      wr_reg(ADDR_CTRL, 32'h0000_0001);
      rd_reg(ADDR_STATUS);
      chk(v, RD_ZERO, "soft clear");
      rd_reg(ADDR_CTRL);
      chk(v, RD_ZERO, "ctrl read");
      rd_reg(8'h08);
      chk(v, RD_ZERO, "unmapped");
   endtask : t_preset
   task t_poly;
      poly_sel_t p;
      crc_word_t c;
      int d;
      for (int s = 0; s < 8; s++) begin
         p = poly_sel_t'(s);
         {sel, check_word_enable} <= {p, 1'b1};
         pins(1'b1, 1'b0);
         c = crc(16'h0000, 32'h0000_B51C ^ s, 16, p);
         send(32'h0000_B51C ^ s, 16);
         rd_reg(ADDR_STATUS);
         chk(v[15:0], c, "remainder");
         chk(v[STAT_SEL_LSB+:3], p, "select");
         chk(err, c != 16'h0000, "error");
         d = $countones(mask_of(p));
         check_word_enable <= 1'b0;
         for (int j = d - 1; j >= 0; j--) begin
            chk(sout, c[j], "check bit");
            send(32'h0000_0001, 1);
         end
         for (int e = 0; e < 2; e++) begin
            check_word_enable <= 1'b1;
            pins(1'b1, 1'b0);
            send((((32'h0000_B51C ^ s) << d) | c) ^ e, 16 + d);
            chk(err, e, "receive");
         end
      end
   endtask : t_poly
   task t_sdlc;
      crc_word_t c;
      {sel, check_word_enable, pme_n} <= {SEL_CCITT, 2'b10};
      pins(1'b0, 1'b1);
      c = crc(16'hFFFF, 32'h0000_5A3C, 16, SEL_CCITT);
      send({16'h5A3C, ~c}, 32);
      rd_reg(ADDR_STATUS);
      chk(v[15:0], SDLC_RESIDUE, "residue");
      chk(err, 1'b0, "pattern");
      pme_n <= 1'b1;
      repeat (4) @(posedge clk_in);
      chk(err, 1'b0, "held");
      send(32'h0000_0000, 1);
      chk(err, crc(SDLC_RESIDUE, 32'h0, 1, SEL_CCITT) != 16'h0000, "zero test");
   endtask : t_sdlc
   task end_sim;
      if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   initial begin
      {arst_n_in, mclr, wr, rd, go, sel, addr, wdata, bits, nb} = '0;
      {check_word_enable, pre_n, pme_n} = 3'b111;
      repeat (8) @(posedge clk_in);
      arst_n_in <= 1'b1;
      t_preset;
      t_poly;
      t_sdlc;
      end_sim;
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      err_count++;
      end_sim;
   end
endmodule : serial_crc_generator_checker_tb
